// >>> common/sns_pkg.sv
package sns_pkg;
  localparam int          DATA_W        = 8;
  localparam int          ADDR_W        = 14;
  localparam int          BANK_W        = 6;
  localparam logic [3:0]  OPC_SUB_HI    = 4'h5;
  localparam logic [3:0]  OPC_SWAP_HI   = 4'h3;
  localparam logic [1:0]  OPC_SUB_LO    = 2'h3;
  localparam logic [1:0]  OPC_SUBB_LO   = 2'h2;
  localparam logic [1:0]  OPC_SWAP_LO   = 2'h2;
  localparam int          POS_DEST      = 9;
  localparam int          POS_ACC       = 8;
  localparam logic [7:0]  IDX_LIMIT     = 8'h5F;
  localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;
  localparam logic [5:0]  SFR_BANK      = 6'h04;
  localparam logic [7:0]  ACC_RST       = 8'h00;
  localparam logic [4:0]  FLAGS_RST     = 5'h00;
  localparam int          FLG_C         = 0;
  localparam int          FLG_DC        = 1;
  localparam int          FLG_Z         = 2;
  localparam int          FLG_OV        = 3;
  localparam int          FLG_N         = 4;

  typedef enum logic [3:0] {
    SNS_Q1 = 4'b0001,
    SNS_Q2 = 4'b0010,
    SNS_Q3 = 4'b0100,
    SNS_Q4 = 4'b1000
  } sns_phase_t;
endpackage : sns_pkg

// >>> hw/sns_core.sv
`timescale 1ns/100ps
module sns_core
  import sns_pkg::*;
#(
  parameter int DW = DATA_W,
  parameter int AW = ADDR_W
) (
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  input  wire logic          instr_valid,
  input  wire logic [15:0]   instr_word,
  input  wire logic          ext_set_en,
  input  wire logic [5:0]    bank_select_pointer,
  input  wire logic [AW-1:0] index_base,
  input  wire logic [DW-1:0] file_rd_data,
  output logic      [AW-1:0] file_addr,
  output logic               file_rd_en,
  output logic               file_wr_en,
  output logic      [DW-1:0] file_wr_data,
  output logic      [DW-1:0] acc_q,
  output logic      [4:0]    flags_q,
  output logic               instr_done,
  output logic               instr_illegal
);

  sns_phase_t      phase_q, phase_d;
  logic [15:0]     ir_q, ir_d;
  logic [DW-1:0]   opnd_q, opnd_d;
  logic [DW-1:0]   acc_d;
  logic [4:0]      flags_d;
  logic [AW-1:0]   addr_d;
  logic            rd_d;
  logic            wr_d;
  logic [DW-1:0]   wr_data_d;
  logic            done_d;
  logic            ill_d;
  logic            in_q2, in_q3, in_q4;
  logic            is_sub, is_subb, is_swap, legal;
  logic            to_file;
  logic            borrow_in;
  logic [DW:0]     diff;
  logic [4:0]      half;
  logic [DW-1:0]   swapped;
  logic [DW-1:0]   result;
  logic [7:0]      fld;

  // decode of the latched word; ir_q holds still from Q2 to Q4
  always_comb begin
    fld     = ir_q[7:0];
    to_file = ir_q[POS_DEST];
    is_sub  = (ir_q[15:12] == OPC_SUB_HI) && (ir_q[11:10] == OPC_SUB_LO);
    is_subb = (ir_q[15:12] == OPC_SUB_HI) && (ir_q[11:10] == OPC_SUBB_LO);
    is_swap = (ir_q[15:12] == OPC_SWAP_HI) && (ir_q[11:10] == OPC_SWAP_LO);
    legal   = is_sub | is_subb | is_swap;
    in_q2   = (phase_q == SNS_Q2);
    in_q3   = (phase_q == SNS_Q3);
    in_q4   = (phase_q == SNS_Q4);
  end

  // sequencer: Q1 idles until a word arrives, Q2..Q4 never stall
  always_comb begin
    phase_d = phase_q;
    ir_d    = ir_q;
    case (phase_q)
      SNS_Q1: begin
        // a word offered outside Q1 is dropped silently; there is no busy port
        if (instr_valid) begin
          ir_d    = instr_word;
          phase_d = SNS_Q2;
        end
      end
      SNS_Q2: begin
        phase_d = SNS_Q3;
      end
      SNS_Q3: begin
        phase_d = SNS_Q4;
      end
      SNS_Q4: begin
        phase_d = SNS_Q1;
      end
      default: begin
        phase_d = SNS_Q1;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      phase_q <= SNS_Q1;
      ir_q    <= 16'h0000;
    end else begin
      phase_q <= phase_d;
      ir_q    <= ir_d;
    end
  end

  // Q2: resolve the file address and strobe the read for legal words only
  always_comb begin
    addr_d = file_addr;
    rd_d   = 1'b0;
    if (in_q2) begin
      if (ir_q[POS_ACC]) begin
        addr_d = AW'({bank_select_pointer, fld});
      end else if (ext_set_en && (fld <= IDX_LIMIT)) begin
        // the sum wraps inside the data space; the base is not range checked
        addr_d = index_base + AW'(fld);
      end else if (fld < ACCESS_SPLIT) begin
        addr_d = AW'({6'h00, fld});
      end else begin
        addr_d = AW'({SFR_BANK, fld});
      end
      rd_d = legal;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      file_addr  <= '0;
      file_rd_en <= 1'b0;
    end else begin
      file_addr  <= addr_d;
      file_rd_en <= rd_d;
    end
  end

  // Q3: the file value is taken at the edge that closes the read strobe
  always_comb begin
    opnd_d = opnd_q;
    if (in_q3) begin
      opnd_d = file_rd_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      opnd_q <= '0;
    end else begin
      opnd_q <= opnd_d;
    end
  end

  // borrow in is the inverted carry; plain subtract has none
  always_comb begin
    borrow_in = is_subb & ~flags_q[FLG_C];
    diff      = {1'b0, opnd_q} - {1'b0, acc_q} - {{DW{1'b0}}, borrow_in};
    half      = {1'b0, opnd_q[3:0]} - {1'b0, acc_q[3:0]} - {4'h0, borrow_in};
    swapped   = {opnd_q[3:0], opnd_q[7:4]};
    result    = is_swap ? swapped : diff[DW-1:0];
  end

  // Q4: result to the accumulator when the destination bit is clear
  always_comb begin
    acc_d   = acc_q;
    flags_d = flags_q;
    if (in_q4 && legal) begin
      if (!to_file) begin
        acc_d = result;
      end
      // nibble exchange keeps every flag; illegal words never get here
      if (!is_swap) begin
        flags_d[FLG_C]  = ~diff[DW];
        flags_d[FLG_DC] = ~half[4];
        flags_d[FLG_Z]  = (diff[DW-1:0] == '0);
        flags_d[FLG_N]  = diff[DW-1];
        flags_d[FLG_OV] = (opnd_q[DW-1] != acc_q[DW-1]) && (diff[DW-1] != opnd_q[DW-1]);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      acc_q   <= ACC_RST;
      flags_q <= FLAGS_RST;
    end else begin
      acc_q   <= acc_d;
      flags_q <= flags_d;
    end
  end

  // Q4: write back to the file register; data holds until the next write
  always_comb begin
    wr_d      = 1'b0;
    wr_data_d = file_wr_data;
    if (in_q4 && legal && to_file) begin
      wr_data_d = result;
      wr_d      = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      file_wr_en   <= 1'b0;
      file_wr_data <= '0;
    end else begin
      file_wr_en   <= wr_d;
      file_wr_data <= wr_data_d;
    end
  end

  // end-of-cycle pulses; an illegal word leaves acc_q, flags_q and the file as they were, though file_addr still moves in Q2
  always_comb begin
    done_d = in_q4 & legal;
    ill_d  = in_q4 & ~legal;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      instr_done    <= 1'b0;
      instr_illegal <= 1'b0;
    end else begin
      instr_done    <= done_d;
      instr_illegal <= ill_d;
    end
  end

endmodule : sns_core

// >>> tb/sns_core_assertions.sv
`timescale 1ns/100ps
module sns_core_assertions (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       file_rd_en,
  input wire logic       file_wr_en,
  input wire logic       instr_done,
  input wire logic [7:0] acc_q,
  input wire logic [4:0] flags_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_rd; file_rd_en |-> ##2 instr_done; endproperty
  a_rd: assert property (p_rd) else $error("no completion after read");
  property p_done; instr_done |-> $past(file_rd_en, 2); endproperty
  a_done: assert property (p_done) else $error("completion without read");
  property p_one; instr_done |=> !instr_done; endproperty
  a_one: assert property (p_one) else $error("completion held");
  property p_wr; file_wr_en |-> instr_done && $stable(acc_q); endproperty
  a_wr: assert property (p_wr) else $error("file write touched acc");
  property p_acc; !instr_done |-> $stable(acc_q); endproperty
  a_acc: assert property (p_acc) else $error("acc moved mid cycle");
  property p_flg; !instr_done |-> $stable(flags_q); endproperty
  a_flg: assert property (p_flg) else $error("flags moved mid cycle");
  property p_z; flags_q[2] |-> flags_q[0] && !flags_q[4]; endproperty
  a_z: assert property (p_z) else $error("zero flag mix");
  property p_n; flags_q[4] |-> !flags_q[2]; endproperty
  a_n: assert property (p_n) else $error("negative with zero");
endmodule : sns_core_assertions
bind sns_core sns_core_assertions u_sns_core_assertions (.ref_clk(ref_clk), .rst_n(rst_n),
  .file_rd_en(file_rd_en), .file_wr_en(file_wr_en), .instr_done(instr_done), .acc_q(acc_q), .flags_q(flags_q));

// >>> tb/sns_core_test.sv
`timescale 1ns/100ps
module sns_core_test;
  logic        ref_clk = 0, rst_n = 0, instr_valid = 0, ext_set_en = 0;
  logic        file_rd_en, file_wr_en, instr_done, instr_illegal;
  logic [15:0] instr_word = '0;
  logic [5:0]  bank_select_pointer = '0;
  logic [13:0] index_base = 14'h0100, file_addr, a_seen;
  logic [7:0]  file_rd_data = '0, file_wr_data, acc_q;
  logic [4:0]  flags_q;
  int          err_count = 0, checks_done = 0, cyc = 0;
  always #10 ref_clk = ~ref_clk;
  sns_core u_sns_core (.ref_clk(ref_clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr_word(instr_word),
    .ext_set_en(ext_set_en), .bank_select_pointer(bank_select_pointer), .index_base(index_base),
    .file_rd_data(file_rd_data), .file_addr(file_addr), .file_rd_en(file_rd_en), .file_wr_en(file_wr_en),
    .file_wr_data(file_wr_data), .acc_q(acc_q), .flags_q(flags_q), .instr_done(instr_done),
    .instr_illegal(instr_illegal));
  task close_out;
    if (err_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count++;
      close_out();
    end
  end
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  // called just after a falling edge; file data is offered only in the read cycle
  task op(input logic [15:0] w, input logic [7:0] f);
    instr_valid = 1;
    instr_word = w;
    @(negedge ref_clk);
    instr_valid = 0;
    @(negedge ref_clk);
    chk("rd_en", file_rd_en, 1);
    a_seen = file_addr;
    file_rd_data = f;
    @(negedge ref_clk);
    file_rd_data = ~f;
    @(negedge ref_clk);
    chk("done", instr_done, 1);
  endtask : op
  task t_sub;
    op(16'h3810, 8'h20);
    chk("acc", acc_q, 8'h02);
    op(16'h5e10, 8'h03);
    chk("wr", {file_wr_en, file_wr_data}, 9'h101);
    chk("flags", flags_q, 5'h03);
    chk("addr", a_seen, 14'h0010);
    op(16'h5e10, 8'h01);
    chk("wr", {file_wr_en, file_wr_data}, 9'h1ff);
    chk("flags", flags_q, 5'h10);
  endtask : t_sub
  task t_subb;
    op(16'h5810, 8'h03);
    chk("acc", {file_wr_en, acc_q}, 9'h000);
    chk("flags", flags_q, 5'h07);
  endtask : t_subb
  task t_swap;
    op(16'h3a20, 8'h53);
    chk("wr", {file_wr_en, file_wr_data}, 9'h135);
    chk("flags", flags_q, 5'h07);
  endtask : t_swap
  task t_addr;
    bank_select_pointer = 6'h05;
    ext_set_en = 1;
    op(16'h3922, 8'h00);
    chk("addr", a_seen, 14'h0522);
    op(16'h385f, 8'h00);
    chk("addr", a_seen, 14'h015f);
    op(16'h3860, 8'h00);
    chk("addr", a_seen, 14'h0460);
  endtask : t_addr
  task t_carry;
    op(16'h3810, 8'hd0);
    chk("acc", acc_q, 8'h0d);
    op(16'h5a10, 8'h19);
    chk("wr", {file_wr_en, file_wr_data}, 9'h10c);
    chk("flags", flags_q, 5'h01);
    chk("addr", a_seen, 14'h0110);
    op(16'h5c10, 8'h80);
    chk("acc", {file_wr_en, acc_q}, 9'h073);
    chk("flags", flags_q, 5'h09);
  endtask : t_carry
  task t_ill;
    instr_valid = 1;
    instr_word = 16'h5410;
    @(negedge ref_clk);
    instr_valid = 0;
    @(negedge ref_clk);
    chk("rd_en", file_rd_en, 0);
    repeat (2) @(negedge ref_clk);
    chk("ill", {instr_done, instr_illegal, file_wr_en}, 3'h2);
    chk("acc", acc_q, 8'h73);
    chk("flags", flags_q, 5'h09);
  endtask : t_ill
  initial begin
    repeat (3) @(negedge ref_clk);
    rst_n = 1;
    t_sub();
    t_subb();
    t_swap();
    t_addr();
    t_carry();
    t_ill();
    close_out();
  end
endmodule : sns_core_test
